/* logic/art_pkg.sv */
// Package of constants and types for the auto-reload capture timer
package art_pkg;

    // ========================================
    // Register bus
    localparam int ART_ADDR_W = 4;
    localparam int ART_DATA_W = 8;

    localparam logic [3:0] ART_OFS_CONTROL = 4'h0;
    localparam logic [3:0] ART_OFS_RELOAD_LOW = 4'h1;
    localparam logic [3:0] ART_OFS_RELOAD_HIGH = 4'h2;
    localparam logic [3:0] ART_OFS_COUNT_LOW = 4'h3;
    localparam logic [3:0] ART_OFS_COUNT_HIGH = 4'h4;
    localparam logic [3:0] ART_OFS_CLOCK_CONFIG = 4'h5;
    localparam logic [3:0] ART_OFS_IRQ_STATUS = 4'h6;
    localparam logic [3:0] ART_OFS_IRQ_MASK = 4'h7;

    // ========================================
    // Field positions
    localparam int ART_CLK_LOW_SEL_BIT = 0;
    localparam int ART_CLK_HIGH_SEL_BIT = 1;
    localparam int ART_IRQ_TIMER_BIT = 0;
    localparam int ART_IRQ_LOW_BIT = 1;

    // ========================================
    // Reset values
    localparam logic [7:0] ART_RST_CONTROL = 8'h00;
    localparam logic [7:0] ART_RST_RELOAD = 8'h00;
    localparam logic [7:0] ART_RST_COUNT = 8'h00;
    localparam logic [1:0] ART_RST_CLOCK_CONFIG = 2'h0;
    localparam logic [1:0] ART_RST_IRQ = 2'h0;

    // ========================================
    // Timing counts
    localparam logic [3:0] ART_SYS_DIV = 4'hc;
    localparam logic [2:0] ART_EXT_DIV_LAST = 3'h7;
    localparam logic [7:0] ART_BYTE_MAX = 8'hff;
    localparam logic [7:0] ART_BYTE_ZERO = 8'h00;

    // ========================================
    // Types
    typedef struct packed {
        logic high_overflow_flag;
        logic low_overflow_flag;
        logic low_byte_irq_enable;
        logic capture_enable;
        logic split_byte_mode;
        logic run_control;
        logic capture_source_select;
        logic external_clock_select;
    } art_ctrl_t;

    typedef struct packed {
        logic [ART_ADDR_W-1:0] addr;
        logic [ART_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } art_bus_req_t;

    typedef enum logic [1:0] {
        ART_MODE_RELOAD16,
        ART_MODE_RELOAD8,
        ART_MODE_CAPTURE16,
        ART_MODE_CAPTURE8
    } art_mode_t;

endpackage

/* logic/art_sync_edge.sv */
// Two-flop synchroniser with rising-edge pulse
`timescale 1ns/1ps
module art_sync_edge
    import art_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic async_in,
    output logic rise_out
);

    logic meta;
    logic stable;
    logic stable_d;

    // ========================================
    // Synchroniser; only the second stage is looked at
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta <= 1'b0;
            stable <= 1'b0;
            stable_d <= 1'b0;
        end else begin
            meta <= async_in;
            stable <= meta;
            stable_d <= stable;
        end
    end

    assign rise_out = stable & ~stable_d;

endmodule

/* logic/art_byte_counter.sv */
// One 8-bit counter byte with wrap, reload and software write
`timescale 1ns/1ps
module art_byte_counter
    import art_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic tick_in,
    input wire logic reload_in,
    input wire logic [7:0] reload_val_in,
    input wire logic wr_in,
    input wire logic [7:0] wr_data_in,
    output logic [7:0] count_out,
    output logic wrap_out
);

    logic [7:0] count;
    logic [7:0] next_count;

    assign wrap_out = tick_in & (count == ART_BYTE_MAX);
    assign count_out = count;

    always_comb begin
        next_count = count;
        if (wr_in) begin
            next_count = wr_data_in;
        end else if (wrap_out) begin
            next_count = reload_in ? reload_val_in : ART_BYTE_ZERO;
        end else if (tick_in) begin
            next_count = count + 8'h01;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count <= ART_RST_COUNT;
        end else begin
            count <= next_count;
        end
    end

endmodule

/* logic/art_timer.sv */
// Auto-reload capture timer: two byte counters, clock select, capture and registers
//
// Notes on behaviour
// - Two 8-bit bytes form a 16-bit counter
// - Count clocks: system, system/12, external/8 synced
// - Split and capture clear: 16-bit reload counter
// - 16-bit rollover loads reload, sets high flag
// - Interrupt on every full 16-bit overflow
// - Low-byte rollover interrupts when low enable set
// - Split mode: two independent 8-bit reload counters
// - Run bit gates high byte only in split
// - Per-byte select: system, else /12 or /8
// - Split mode sets each byte's overflow flag
// - Split interrupts: high, or either with enable
// - Flags cleared only by software writes
// - Capture source select picks frame-start or oscillator edge
// - Capture 16-bit: wrap, latch both bytes, interrupt
// - Capture split: bytes wrap alone, latch, interrupt
// - Low overflow flag sets in every mode
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module art_timer
    import art_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire art_bus_req_t bus_req_in,
    output logic [ART_DATA_W-1:0] rdata_out,
    input wire logic ext_osc_in,
    input wire logic low_freq_oscillator_in,
    input wire logic frame_start_in,
    output logic irq_out,
    output logic [7:0] count_low_byte_out,
    output logic [7:0] count_high_byte_out
);

    // ========================================
    // Registers
    art_ctrl_t timer_control_reg;
    logic [7:0] reload_low_byte;
    logic [7:0] reload_high_byte;
    logic [1:0] clock_config_reg;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [ART_DATA_W-1:0] rdata;

    // ========================================
    // Internal signals
    art_mode_t mode;
    logic [3:0] sys_div_count;
    logic sys_div_tick;
    logic [2:0] ext_div_count;
    logic ext_div_tick;
    logic ext_rise;
    logic lfo_rise;
    logic sof_rise;
    logic capture_event;
    logic alt_tick;
    logic low_sel_tick;
    logic high_sel_tick;
    logic low_tick;
    logic high_tick;
    logic low_reload;
    logic high_reload;
    logic low_wrap;
    logic high_wrap;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic wr_control;
    logic wr_reload_low;
    logic wr_reload_high;
    logic wr_count_low;
    logic wr_count_high;
    logic wr_clock_config;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic set_high_flag;
    logic set_low_flag;
    logic timer_event;
    logic low_event;
    logic reload_mode;

    // ========================================
    // Write decode
    assign wr_control = bus_req_in.wr && (bus_req_in.addr == ART_OFS_CONTROL);
    assign wr_reload_low = bus_req_in.wr && (bus_req_in.addr == ART_OFS_RELOAD_LOW);
    assign wr_reload_high = bus_req_in.wr && (bus_req_in.addr == ART_OFS_RELOAD_HIGH);
    assign wr_count_low = bus_req_in.wr && (bus_req_in.addr == ART_OFS_COUNT_LOW);
    assign wr_count_high = bus_req_in.wr && (bus_req_in.addr == ART_OFS_COUNT_HIGH);
    assign wr_clock_config = bus_req_in.wr && (bus_req_in.addr == ART_OFS_CLOCK_CONFIG);
    assign wr_irq_status = bus_req_in.wr && (bus_req_in.addr == ART_OFS_IRQ_STATUS);
    assign wr_irq_mask = bus_req_in.wr && (bus_req_in.addr == ART_OFS_IRQ_MASK);

    // ========================================
    // Mode decode
    always_comb begin
        case ({timer_control_reg.capture_enable, timer_control_reg.split_byte_mode})
            2'b00: mode = ART_MODE_RELOAD16;
            2'b01: mode = ART_MODE_RELOAD8;
            2'b10: mode = ART_MODE_CAPTURE16;
            2'b11: mode = ART_MODE_CAPTURE8;
            default: mode = ART_MODE_RELOAD16;
        endcase
    end

    assign reload_mode = (mode == ART_MODE_RELOAD16) || (mode == ART_MODE_RELOAD8);

    // ========================================
    // Pin inputs, each through two flops first
    art_sync_edge u_sync_ext (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .async_in(ext_osc_in),
        .rise_out(ext_rise)
    );

    art_sync_edge u_sync_lfo (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .async_in(low_freq_oscillator_in),
        .rise_out(lfo_rise)
    );

    art_sync_edge u_sync_sof (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .async_in(frame_start_in),
        .rise_out(sof_rise)
    );

    // Edge detect gives exactly one pulse per event
    assign capture_event = timer_control_reg.capture_enable
        && (timer_control_reg.capture_source_select ? lfo_rise : sof_rise);

    // ========================================
    // Dividers producing enable pulses
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sys_div_count <= 4'h0;
        end else if (sys_div_tick) begin
            sys_div_count <= 4'h0;
        end else begin
            sys_div_count <= sys_div_count + 4'h1;
        end
    end

    assign sys_div_tick = (sys_div_count == ART_SYS_DIV - 4'h1);

    // External clock counted in synchronised edges, so it may not exceed half clk_in
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ext_div_count <= 3'h0;
        end else if (ext_rise) begin
            ext_div_count <= ext_div_count + 3'h1;
        end
    end

    assign ext_div_tick = ext_rise && (ext_div_count == ART_EXT_DIV_LAST);

    // ========================================
    // Clock selection per byte
    assign alt_tick = timer_control_reg.external_clock_select ? ext_div_tick : sys_div_tick;
    assign low_sel_tick = clock_config_reg[ART_CLK_LOW_SEL_BIT] ? 1'b1 : alt_tick;
    assign high_sel_tick = clock_config_reg[ART_CLK_HIGH_SEL_BIT] ? 1'b1 : alt_tick;

    always_comb begin
        low_tick = 1'b0;
        high_tick = 1'b0;
        low_reload = 1'b0;
        high_reload = 1'b0;
        case (mode)
            ART_MODE_RELOAD16: begin
                low_tick = low_sel_tick && timer_control_reg.run_control;
                high_tick = low_wrap;
                // Low byte reloads only when the whole word overflows
                low_reload = high_wrap;
                high_reload = 1'b1;
            end
            ART_MODE_RELOAD8: begin
                // Low byte free-runs in split mode
                low_tick = low_sel_tick;
                high_tick = high_sel_tick && timer_control_reg.run_control;
                low_reload = 1'b1;
                high_reload = 1'b1;
            end
            ART_MODE_CAPTURE16: begin
                low_tick = low_sel_tick && timer_control_reg.run_control;
                high_tick = low_wrap;
            end
            ART_MODE_CAPTURE8: begin
                low_tick = low_sel_tick;
                high_tick = high_sel_tick && timer_control_reg.run_control;
            end
            default: begin
                low_tick = 1'b0;
                high_tick = 1'b0;
            end
        endcase
    end

    // ========================================
    // Counter bytes
    art_byte_counter u_low (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .tick_in(low_tick),
        .reload_in(low_reload),
        .reload_val_in(reload_low_byte),
        .wr_in(wr_count_low),
        .wr_data_in(bus_req_in.wdata),
        .count_out(count_low_byte),
        .wrap_out(low_wrap)
    );

    art_byte_counter u_high (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .tick_in(high_tick),
        .reload_in(high_reload),
        .reload_val_in(reload_high_byte),
        .wr_in(wr_count_high),
        .wr_data_in(bus_req_in.wdata),
        .count_out(count_high_byte),
        .wrap_out(high_wrap)
    );

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count_low_byte_out <= ART_RST_COUNT;
            count_high_byte_out <= ART_RST_COUNT;
        end else begin
            count_low_byte_out <= count_low_byte;
            count_high_byte_out <= count_high_byte;
        end
    end

    // ========================================
    // Reload bytes; a capture wins over a software write
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reload_low_byte <= ART_RST_RELOAD;
            reload_high_byte <= ART_RST_RELOAD;
        end else if (capture_event) begin
            reload_low_byte <= count_low_byte;
            reload_high_byte <= count_high_byte;
        end else begin
            if (wr_reload_low) begin
                reload_low_byte <= bus_req_in.wdata;
            end
            if (wr_reload_high) begin
                reload_high_byte <= bus_req_in.wdata;
            end
        end
    end

    // ========================================
    // Control register and overflow flags
    assign set_high_flag = high_wrap;
    assign set_low_flag = low_wrap;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            timer_control_reg <= art_ctrl_t'(ART_RST_CONTROL);
        end else begin
            if (wr_control) begin
                timer_control_reg <= art_ctrl_t'(bus_req_in.wdata);
            end
            // Flags only set here; software clears by writing zero, a set wins
            if (set_high_flag) begin
                timer_control_reg.high_overflow_flag <= 1'b1;
            end
            if (set_low_flag) begin
                timer_control_reg.low_overflow_flag <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            clock_config_reg <= ART_RST_CLOCK_CONFIG;
        end else if (wr_clock_config) begin
            clock_config_reg <= bus_req_in.wdata[1:0];
        end
    end

    // ========================================
    // Interrupt events
    always_comb begin
        timer_event = 1'b0;
        low_event = 1'b0;
        if (reload_mode) begin
            timer_event = high_wrap;
            low_event = low_wrap && timer_control_reg.low_byte_irq_enable;
        end else begin
            timer_event = capture_event;
        end
    end

    // Sticky status, write one to clear, event wins
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_status <= ART_RST_IRQ;
        end else begin
            irq_status <= (irq_status & ~(wr_irq_status ? bus_req_in.wdata[1:0] : 2'h0))
                | {low_event, timer_event};
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_mask <= ART_RST_IRQ;
        end else if (wr_irq_mask) begin
            irq_mask <= bus_req_in.wdata[1:0];
        end
    end

    // Mask bits stand for the timer interrupt enables
    assign irq_out = |(irq_status & irq_mask);

    // ========================================
    // Read path, data one cycle after the strobe
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata <= 8'h00;
        end else if (bus_req_in.rd) begin
            case (bus_req_in.addr)
                ART_OFS_CONTROL: rdata <= timer_control_reg;
                ART_OFS_RELOAD_LOW: rdata <= reload_low_byte;
                ART_OFS_RELOAD_HIGH: rdata <= reload_high_byte;
                ART_OFS_COUNT_LOW: rdata <= count_low_byte;
                ART_OFS_COUNT_HIGH: rdata <= count_high_byte;
                ART_OFS_CLOCK_CONFIG: rdata <= {6'h00, clock_config_reg};
                ART_OFS_IRQ_STATUS: rdata <= {6'h00, irq_status};
                ART_OFS_IRQ_MASK: rdata <= {6'h00, irq_mask};
                default: rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    assign rdata_out = rdata;

endmodule

/* test/art_far_side.sv */
// Far-side model: frame-start source, slow oscillator and external clock
`timescale 1ns/1ps
module art_far_side (
    input wire logic clk_in,
    output logic frame_start_out,
    output logic lfo_out,
    output logic ext_osc_out
);
    // ========================================
    // Idle levels
    initial begin
        frame_start_out = 1'b0;
        lfo_out = 1'b0;
        ext_osc_out = 1'b0;
    end

    // ========================================
    // Event sources
    // Held several cycles so the synchroniser cannot miss it
    task automatic send_frame();
        @(posedge clk_in);
        frame_start_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        frame_start_out <= 1'b0;
    endtask

    task automatic lfo_rise();
        @(posedge clk_in);
        lfo_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        lfo_out <= 1'b0;
    endtask

    // Exactly n rising edges, then stands still low
    task automatic ext_pulses(input int n);
        repeat (n) begin
            repeat (3) @(posedge clk_in);
            ext_osc_out <= 1'b1;
            repeat (3) @(posedge clk_in);
            ext_osc_out <= 1'b0;
        end
    endtask
endmodule

/* test/art_timer_props.sv */
// Concurrent checks for the auto-reload capture timer
`timescale 1ns/1ps
module art_timer_props
    import art_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire art_bus_req_t bus_req_in,
    input wire logic [ART_DATA_W-1:0] rdata_out,
    input wire logic ext_osc_in,
    input wire logic low_freq_oscillator_in,
    input wire logic frame_start_in,
    input wire logic irq_out,
    input wire logic [7:0] count_low_byte_out,
    input wire logic [7:0] count_high_byte_out
);
    // ========================================
    // Shadows of software writes
    logic [7:0] ctl;
    logic [7:0] rl_lo;
    logic [1:0] cfg;
    logic [1:0] msk;
    logic [2:0] quiet;
    logic st;
    logic [7:0] lo;
    logic [7:0] hi;
    assign lo = count_low_byte_out;
    assign hi = count_high_byte_out;
    // Counts lag the registers, so settle a few cycles after any write
    assign st = (quiet >= 3'h3) && !bus_req_in.wr;

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ctl <= 8'h00;
            rl_lo <= 8'h00;
            cfg <= 2'h0;
            msk <= 2'h0;
            quiet <= 3'h0;
        end else begin
            quiet <= bus_req_in.wr ? 3'h0 : ((quiet == 3'h7) ? 3'h7 : quiet + 3'h1);
            if (bus_req_in.wr) begin
                case (bus_req_in.addr)
                    ART_OFS_CONTROL: ctl <= bus_req_in.wdata;
                    ART_OFS_RELOAD_LOW: rl_lo <= bus_req_in.wdata;
                    ART_OFS_CLOCK_CONFIG: cfg <= bus_req_in.wdata[1:0];
                    ART_OFS_IRQ_MASK: msk <= bus_req_in.wdata[1:0];
                    default: ;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    // ========================================
    // Properties
    property p_hold16;
        st && !ctl[3] && !ctl[4] && !ctl[2] |=> $stable(lo) && $stable(hi);
    endproperty
    a_hold16: assert property (p_hold16) else $error("16-bit count moved while stopped");
    property p_reload16;
        st && ctl[2] && !ctl[3] && !ctl[4] && cfg[0] && lo == 8'hff && hi == 8'hff
            |=> lo == rl_lo;
    endproperty
    a_reload16: assert property (p_reload16) else $error("no reload on full wrap");
    property p_irq16;
        st && ctl[2] && !ctl[3] && !ctl[4] && cfg[0] && msk[0] && lo == 8'hff
            && hi == 8'hff |-> ##[0:3] irq_out;
    endproperty
    a_irq16: assert property (p_irq16) else $error("no interrupt on full wrap");
    property p_split_reload;
        st && ctl[3] && !ctl[4] && cfg[0] && lo == 8'hff |=> lo == rl_lo;
    endproperty
    a_split_reload: assert property (p_split_reload) else $error("low byte not reloaded");
    property p_split_hold;
        st && ctl[3] && !ctl[4] && !ctl[2] |=> $stable(hi);
    endproperty
    a_split_hold: assert property (p_split_hold) else $error("high byte ran while stopped");
    property p_tick_sys;
        st && !ctl[4] && cfg[0] && (ctl[3] || ctl[2]) && lo != 8'hff |=> lo == $past(lo) + 8'h01;
    endproperty
    a_tick_sys: assert property (p_tick_sys) else $error("low byte missed a tick");
    property p_div12;
        st && !cfg[0] && !ctl[0] && ctl[2] && !ctl[3] && !ctl[4] && $changed(lo) |=> $stable(lo);
    endproperty
    a_div12: assert property (p_div12) else $error("divided tick too fast");
    property p_cap_wrap;
        st && ctl[4] && ctl[3] && ctl[2] && cfg[0] && lo == 8'hff |=> lo == 8'h00;
    endproperty
    a_cap_wrap: assert property (p_cap_wrap) else $error("capture byte wrap wrong");
    property p_mask_off;
        msk == 2'h0 |-> !irq_out;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("interrupt with all masked");

    c_wrap16: cover property (st && ctl[2] && !ctl[3] && lo == 8'hff && hi == 8'hff);
    c_split: cover property (st && ctl[3] && !ctl[4] && lo == 8'hff);
    c_cap_irq: cover property (ctl[4] && irq_out);
endmodule

bind art_timer art_timer_props u_props (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .bus_req_in(bus_req_in), .rdata_out(rdata_out), .ext_osc_in(ext_osc_in),
    .low_freq_oscillator_in(low_freq_oscillator_in), .frame_start_in(frame_start_in),
    .irq_out(irq_out), .count_low_byte_out(count_low_byte_out),
    .count_high_byte_out(count_high_byte_out));

/* test/tb_art_timer.sv */
// Self-checking bench for the auto-reload capture timer
`timescale 1ns/1ps
module tb_art_timer;
    import art_pkg::*;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    art_bus_req_t bus = '0;
    logic [7:0] rdata;
    logic ext_osc;
    logic low_freq_oscillator;
    logic frame;
    logic irq;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    int fails = 0;
    int n_compared = 0;

    always #2.5 clk_in = ~clk_in;

    art_timer dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_req_in(bus),
        .rdata_out(rdata), .ext_osc_in(ext_osc), .low_freq_oscillator_in(low_freq_oscillator),
        .frame_start_in(frame), .irq_out(irq), .count_low_byte_out(cnt_lo),
        .count_high_byte_out(cnt_hi));
    art_far_side far (.clk_in(clk_in), .frame_start_out(frame), .lfo_out(low_freq_oscillator),
        .ext_osc_out(ext_osc));

    // ========================================
    // Tasks
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input int a, input logic [7:0] d);
        @(posedge clk_in);
        bus <= '{addr: a[3:0], wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input int a, input logic [7:0] exp, input string what);
        @(posedge clk_in);
        bus <= '{addr: a[3:0], wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus.rd <= 1'b0;
        #1 chk(what, exp, rdata);
    endtask

    // Hang guard
    initial begin
        #50us;
        fails++;
        end_sim();
    end

    // ========================================
    // Scenarios
    initial begin
        repeat (3) @(posedge clk_in);
        arst_n_in <= 1'b1;
        for (int a = 0; a < 9; a++) rd(a, 8'h00, "reset");
        // 16-bit reload; low clock taken from idle oscillator to freeze
        wr(1, 8'h10);
        wr(2, 8'hff);
        wr(3, 8'hf8);
        wr(4, 8'hff);
        wr(7, 8'h03);
        wr(5, 8'h01);
        wr(0, 8'h25);
        repeat (14) @(posedge clk_in);
        wr(5, 8'h00);
        rd(0, 8'he5, "flags16");
        rd(4, 8'hff, "high16");
        rd(6, 8'h03, "status16");
        chk("irq", 8'h01, {7'h0, irq});
        wr(7, 8'h00);
        // Mask lands on this edge; look once it has settled
        #1 chk("irq masked", 8'h00, {7'h0, irq});
        wr(7, 8'h01);
        wr(6, 8'h03);
        rd(6, 8'h00, "status clr");
        chk("irq clr", 8'h00, {7'h0, irq});
        rd(0, 8'he5, "flags kept");
        wr(0, 8'h00);
        rd(0, 8'h00, "flags clr");
        wr(0, 8'h04);
        repeat (60) @(posedge clk_in);
        // Split mode, high stopped
        wr(1, 8'hfc);
        wr(3, 8'hfa);
        wr(4, 8'h05);
        wr(0, 8'h09);
        wr(5, 8'h01);
        repeat (8) @(posedge clk_in);
        wr(5, 8'h00);
        rd(0, 8'h49, "split flags");
        rd(4, 8'h05, "high held");
        rd(6, 8'h00, "split status");
        // Both bytes on divided external clock, two ticks
        wr(3, 8'h00);
        wr(4, 8'hfe);
        wr(2, 8'ha0);
        wr(0, 8'h0d);
        far.ext_pulses(16);
        repeat (10) @(posedge clk_in);
        rd(4, 8'ha0, "high reload");
        rd(3, 8'h02, "low ext");
        chk("low out", 8'h02, cnt_lo);
        chk("high out", 8'ha0, cnt_hi);
        rd(0, 8'h8d, "high flag");
        rd(6, 8'h01, "high event");
        chk("irq split", 8'h01, {7'h0, irq});
        wr(6, 8'h03);
        wr(0, 8'h29);
        wr(3, 8'hfe);
        wr(5, 8'h01);
        repeat (4) @(posedge clk_in);
        wr(5, 8'h00);
        rd(6, 8'h02, "low event");
        // Capture: all bytes frozen, every source and layout
        wr(5, 8'h02);
        for (int k = 0; k < 4; k++) begin
            wr(0, {3'b000, 1'b1, k[0], 1'b0, k[1], 1'b1});
            wr(3, 8'h30 + k[7:0]);
            wr(4, 8'h40 + k[7:0]);
            wr(6, 8'h03);
            if (k[1]) far.send_frame(); else far.lfo_rise();
            repeat (6) @(posedge clk_in);
            rd(6, 8'h00, "wrong source");
            if (k[1]) far.lfo_rise(); else far.send_frame();
            repeat (6) @(posedge clk_in);
            rd(1, 8'h30 + k[7:0], "cap low");
            rd(2, 8'h40 + k[7:0], "cap high");
            rd(6, 8'h01, "cap event");
        end
        wr(5, 8'h03);
        wr(0, 8'h1d);
        repeat (300) @(posedge clk_in);
        end_sim();
    end
endmodule
